// >>> logic/ccwc_chain.sv
/*
 chaining sequencer of a byte-multiplexing channel: data chaining, command
 chaining, branch command and status-modifier skip.
 assumes: storage answers each request with a one-cycle ack (read data valid
 with it); the ack stands for the end of the storage cycle's write clocks.
 status, selection done and data-cycle strobes come from same-clock logic;
 operational-in is a pin and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module ccwc_chain
    import ccwc_pkg::*;
#(
    parameter logic [5:0] UCW_BASE   = 6'h00,
    parameter logic [8:0] ADDR_LIMIT = 9'h007
)
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // storage port
    output logic                   stor_req_o,
    output logic                   stor_we_o,
    output logic [ADDR_W-1:0]      stor_addr_o,
    output logic [DATA_W-1:0]      stor_wdata_o,
    input  wire logic              stor_ack_i,
    input  wire logic [DATA_W-1:0] stor_rdata_i,
    // channel context
    input  wire logic [7:0]        car_i,
    input  wire logic              data_cycle_i,
    input  wire logic              count_dec_i,
    input  wire logic              burst_i,
    input  wire logic              op_in_i,
    input  wire logic              first_cycle_i,
    input  wire logic              incorrect_len_i,
    input  wire logic              start_io_i,
    input  wire logic              caw_cycle_i,
    // status from control unit
    input  wire logic              status_valid_i,
    input  wire logic [7:0]        status_i,
    // reselection
    output logic                   sel_start_o,
    input  wire logic              sel_done_i,
    // channel registers and events
    output logic [7:0]             cmd_o,
    output logic [7:0]             chan_data_o,
    output logic [7:0]             flags_o,
    output logic [15:0]            count_o,
    output logic [ADDR_W-1:0]      data_addr_o,
    output logic                   cc_latch_o,
    output logic                   dc_latch_o,
    output logic                   prog_check_o,
    output logic                   irq_req_o,
    output logic                   busy_o
);
    logic              rst_q1, rst_n, op_in;
    ccwc_state_t       state, next_state;
    logic              req, next_req, we, next_we, sel, next_sel, irq, next_irq;
    logic [ADDR_W-1:0] addr, next_addr, d_reg, next_d_reg, e_reg, next_e_reg;
    logic [ADDR_W-1:0] da, next_da;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic [7:0]        cmd, next_cmd, cdr, next_cdr, flags, next_flags;
    logic [15:0]       count, next_count;
    logic              cc, next_cc, dc, next_dc, modl, next_modl;
    logic              br, next_br, pchk, next_pchk;
    logic              is_branch, br_fault, dev_end, suppress, count_zero;

    function automatic logic [ADDR_W-1:0] ucw_addr(input logic [7:0] a, input logic [3:0] off);
        ucw_addr = {UCW_BASE, a, off};
    endfunction

    // reset release through two flops; only constants under reset
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    ccwc_sync u_op_sync
    (
        .clk_i (clk_i),
        .rst_n (rst_n),
        .d_i   (op_in_i),
        .q_o   (op_in)
    );

    ccwc_branch_check #(.ADDR_LIMIT(ADDR_LIMIT)) u_branch
    (
        .word_i        (stor_rdata_i),
        .start_io_i    (start_io_i),
        .caw_cycle_i   (caw_cycle_i),
        .branch_last_i (br),
        .is_branch_o   (is_branch),
        .prog_check_o  (br_fault)
    );

    // status decode; error conditions block command chaining
    assign count_zero = (count == 16'h0000);
    assign dev_end    = status_valid_i && status_i[ST_DEV_END];
    assign suppress   = status_i[ST_UNIT_CHK] || status_i[ST_UNIT_EXC] || pchk
                        || (incorrect_len_i && !flags[FL_LEN_SUP]);

    // sequencer next state; storage requests are raised on entry to a cycle
    always_comb
    begin
        next_state = state;
        next_req   = req;
        next_we    = we;
        next_addr  = addr;
        next_wdata = wdata;
        next_d_reg = d_reg;
        next_e_reg = e_reg;
        next_da    = da;
        next_cmd   = cmd;
        next_cdr   = cdr;
        next_flags = flags;
        next_count = count;
        next_cc    = cc;
        next_dc    = dc;
        next_modl  = modl;
        next_br    = br;
        next_pchk  = pchk;
        next_sel   = 1'b0;
        next_irq   = 1'b0;
        // clear first, so a check found in the same cycle wins
        if (start_io_i)
        begin
            next_pchk = 1'b0;
        end
        if (req && stor_ack_i)
        begin
            next_req = 1'b0;
        end
        unique case (state)
            CCWC_IDLE:
            begin
                if (count_dec_i && !count_zero)
                begin
                    next_count = 16'(count - 16'h0001);
                end
                if (data_cycle_i && count_zero && flags[FL_DATA_CHAIN])
                begin
                    next_dc    = 1'b1;
                    next_state = CCWC_W3F;
                    next_req   = 1'b1;
                    next_we    = 1'b0;
                    next_addr  = ucw_addr(car_i, OFF_UCW3);
                end
                else if (dev_end && suppress)
                begin
                    next_irq = 1'b1;
                end
                else if (dev_end && flags[FL_CMD_CHAIN] && (first_cycle_i || count_zero || flags[FL_LEN_SUP]))
                begin
                    next_cc    = 1'b1;
                    next_modl  = status_i[ST_MODIFIER];
                    next_state = CCWC_W3F;
                    next_req   = 1'b1;
                    next_we    = 1'b0;
                    next_addr  = ucw_addr(car_i, OFF_UCW3);
                end
                else if (start_io_i)
                begin
                    next_state = CCWC_W3F; // new operation: word 3 names the first word
                    next_req   = 1'b1;
                    next_we    = 1'b0;
                    next_addr  = ucw_addr(car_i, OFF_UCW3);
                end
            end
            CCWC_W3F:
            begin
                if (stor_ack_i)
                begin
                    next_e_reg = stor_rdata_i[ADDR_W-1:0];
                    next_d_reg = ADDR_W'(stor_rdata_i[ADDR_W-1:0] + CCW_STEP);
                    next_state = CCWC_W3S;
                    next_req   = 1'b1;
                    next_we    = 1'b1;
                    next_wdata = {14'h0000, next_d_reg};
                end
            end
            CCWC_W3S:
            begin
                if (stor_ack_i && modl)
                begin
                    // second pass leaves d at +16, e at +8
                    next_modl  = 1'b0;
                    next_state = CCWC_W3F;
                    next_req   = 1'b1;
                    next_we    = 1'b0;
                end
                else if (stor_ack_i)
                begin
                    next_state = CCWC_C1F;
                    next_req   = 1'b1;
                    next_we    = 1'b0;
                    next_addr  = e_reg;
                end
            end
            CCWC_C1F:
            begin
                if (stor_ack_i && br_fault)
                begin
                    // abandon the chain; interrupt reports the check
                    next_pchk  = 1'b1;
                    next_irq   = 1'b1;
                    next_cc    = 1'b0;
                    next_dc    = 1'b0;
                    next_br    = 1'b0;
                    next_state = CCWC_IDLE;
                end
                else if (stor_ack_i && is_branch)
                begin
                    next_br    = 1'b1;
                    next_e_reg = stor_rdata_i[ADDR_W-1:0];
                    next_d_reg = ADDR_W'(stor_rdata_i[ADDR_W-1:0] + CCW_STEP);
                    next_state = CCWC_W3S;
                    next_req   = 1'b1;
                    next_we    = 1'b1;
                    next_addr  = ucw_addr(car_i, OFF_UCW3);
                    next_wdata = {14'h0000, next_d_reg};
                end
                else if (stor_ack_i)
                begin
                    next_br = 1'b0;
                    next_da = stor_rdata_i[ADDR_W-1:0];
                    if (cc)
                    begin
                        next_cmd = stor_rdata_i[31:24];
                        next_cdr = stor_rdata_i[31:24];
                    end
                    next_state = CCWC_C2F;
                    next_req   = 1'b1;
                    next_we    = 1'b0;
                    next_addr  = e_reg | CCW2_BIT;
                end
            end
            CCWC_C2F:
            begin
                if (stor_ack_i)
                begin
                    next_count = stor_rdata_i[15:0];
                    next_flags = stor_rdata_i[31:24];
                    if (cc)
                    begin
                        next_sel   = 1'b1;
                        next_state = CCWC_SEL;
                    end
                    else if (burst_i || op_in)
                    begin
                        next_dc    = 1'b0;
                        next_state = CCWC_IDLE;
                    end
                    else
                    begin
                        next_state = CCWC_U1S;
                        next_req   = 1'b1;
                        next_we    = 1'b1;
                        next_addr  = ucw_addr(car_i, OFF_UCW1);
                        next_wdata = {cmd, 6'h00, da};
                    end
                end
            end
            CCWC_SEL:
            begin
                if (sel_done_i)
                begin
                    next_cc = 1'b0;
                    if (op_in)
                    begin
                        next_state = CCWC_IDLE;
                    end
                    else
                    begin
                        next_state = CCWC_U1S;
                        next_req   = 1'b1;
                        next_we    = 1'b1;
                        next_addr  = ucw_addr(car_i, OFF_UCW1);
                        next_wdata = {cmd, 6'h00, da};
                    end
                end
            end
            CCWC_U1S:
            begin
                if (stor_ack_i)
                begin
                    next_state = CCWC_U2S;
                    next_req   = 1'b1;
                    next_addr  = ucw_addr(car_i, OFF_UCW2);
                    next_wdata = {flags, 8'h00, count};
                end
            end
            CCWC_U2S:
            begin
                if (stor_ack_i)
                begin
                    next_dc    = 1'b0;
                    next_we    = 1'b0;
                    next_state = CCWC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= CCWC_IDLE;
            req   <= 1'b0;
            we    <= 1'b0;
            addr  <= RST_ADDR;
            wdata <= 32'h00000000;
            d_reg <= RST_ADDR;
            e_reg <= RST_ADDR;
            da    <= RST_ADDR;
            cmd   <= RST_BYTE;
            cdr   <= RST_BYTE;
            flags <= RST_BYTE;
            count <= RST_COUNT;
            cc    <= 1'b0;
            dc    <= 1'b0;
            modl  <= 1'b0;
            br    <= 1'b0;
            pchk  <= 1'b0;
            sel   <= 1'b0;
            irq   <= 1'b0;
        end
        else
        begin
            state <= next_state;
            req   <= next_req;
            we    <= next_we;
            addr  <= next_addr;
            wdata <= next_wdata;
            d_reg <= next_d_reg;
            e_reg <= next_e_reg;
            da    <= next_da;
            cmd   <= next_cmd;
            cdr   <= next_cdr;
            flags <= next_flags;
            count <= next_count;
            cc    <= next_cc;
            dc    <= next_dc;
            modl  <= next_modl;
            br    <= next_br;
            pchk  <= next_pchk;
            sel   <= next_sel;
            irq   <= next_irq;
        end
    end

    // outputs straight from flops, busy_o decoded from state
    assign stor_req_o   = req;
    assign stor_we_o    = we;
    assign stor_addr_o  = addr;
    assign stor_wdata_o = wdata;
    assign sel_start_o  = sel;
    assign cmd_o        = cmd;
    assign chan_data_o  = cdr;
    assign flags_o      = flags;
    assign count_o      = count;
    assign data_addr_o  = da;
    assign cc_latch_o   = cc;
    assign dc_latch_o   = dc;
    assign prog_check_o = pchk;
    assign irq_req_o    = irq;
    assign busy_o       = (state != CCWC_IDLE);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_c2f_done;
        state == CCWC_C2F && stor_ack_i;
    endsequence

    a_word2_addr: assert property (state == CCWC_C2F && req |-> addr == (e_reg | CCW2_BIT))
        else $error("word 2 address lacks bit 29");
    a_resume_service: assert property (s_c2f_done and (!cc && (burst_i || op_in)) |=> state == CCWC_IDLE)
        else $error("data chaining did not resume service");
    a_suppress_irq: assert property (state == CCWC_IDLE && !data_cycle_i && dev_end && suppress
                                     |=> irq && !cc)
        else $error("error did not suppress chaining");
    a_immed_chain: assert property (state == CCWC_IDLE && !data_cycle_i && dev_end && !suppress
                                    && flags[FL_CMD_CHAIN] && first_cycle_i |=> cc)
        else $error("immediate operation did not chain");
    a_sel_start: assert property (s_c2f_done and cc |=> sel_start_o && state == CCWC_SEL ##1 !sel_start_o)
        else $error("selection not started after word 2");
    a_branch_sum: assert property (state == CCWC_C1F && stor_ack_i && is_branch && !br_fault
                                   |=> d_reg == ADDR_W'($past(stor_rdata_i[17:0]) + CCW_STEP)
                                   && e_reg == $past(stor_rdata_i[17:0]))
        else $error("branch target not loaded");
    a_mod_refetch: assert property (state == CCWC_W3S && stor_ack_i && modl |=> state == CCWC_W3F
                                    ##[1:1000] state == CCWC_W3S)
        else $error("modifier did not refetch word 3");
    a_ucw3_addr: assert property ((state == CCWC_W3F || state == CCWC_W3S) && req |-> addr[3] && addr[2:0] == 3'h0)
        else $error("word 3 address wrong");
    a_dc_set: assert property (state == CCWC_IDLE && data_cycle_i && count_zero && flags[FL_DATA_CHAIN]
                               |=> dc && req && !we)
        else $error("data chaining not started");
    a_branch_fault: assert property (state == CCWC_C1F && stor_ack_i && br_fault |=> pchk && irq
                                     && state == CCWC_IDLE)
        else $error("branch fault not flagged");
endmodule
`default_nettype wire

// >>> common/ccwc_pkg.sv
/*
 constants, field positions and state encoding for the chaining sequencer.
 assumes: storage words are 32 bits with the big-endian bit numbering mapped
 so that printed bit n of a word sits at index 31-n, and printed bit n of a
 status or flag byte at index 7-n.
*/
// How it works
// - second word fetch forces address bit 29
// - resume service, else store subchannel words 1-2
// - errors suppress command chaining, request interrupt
// - immediate operation chains on device end anyway
// - otherwise chain only on zero count or suppress
// - command chaining also loads command and data byte
// - word-2 fetch end starts control unit reselection
// - operational-in down after selection: store words 1-2
// - command code 1000 marks branch command
// - illegal branch gives program check and interrupt
// - branch loads target, stores target plus eight
// - word-3 store end fetches branch target word
// - after branch: resume service, reselect or store words 1-2
// - status modifier skips to sixteen bytes ahead
// - modifier latch refetches word 3, adds eight again
// - zero count with data chain flag starts chaining
// - word 3 address forces address bit 28
package ccwc_pkg;
    localparam int          ADDR_W        = 18;
    localparam int          DATA_W        = 32;
    localparam logic [3:0]  OFF_UCW1      = 4'h0;
    localparam logic [3:0]  OFF_UCW2      = 4'h4;
    localparam logic [3:0]  OFF_UCW3      = 4'h8;   // bit 28 forced
    localparam logic [17:0] CCW2_BIT      = 18'h00004; // bit 29 forced
    localparam logic [17:0] CCW_STEP      = 18'h00008;
    localparam logic [3:0]  BRANCH_CODE   = 4'h8;
    localparam int          ST_DEV_END    = 2;
    localparam int          ST_MODIFIER   = 6;
    localparam int          ST_UNIT_CHK   = 1;
    localparam int          ST_UNIT_EXC   = 0;
    localparam int          FL_DATA_CHAIN = 7;
    localparam int          FL_CMD_CHAIN  = 6;
    localparam int          FL_LEN_SUP    = 5;
    localparam logic [15:0] RST_COUNT     = 16'h0000;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [17:0] RST_ADDR      = 18'h00000;

    typedef enum logic [2:0] {
        CCWC_IDLE = 3'b000,
        CCWC_W3F  = 3'b001,
        CCWC_W3S  = 3'b011,
        CCWC_C1F  = 3'b010,
        CCWC_C2F  = 3'b110,
        CCWC_SEL  = 3'b111,
        CCWC_U1S  = 3'b101,
        CCWC_U2S  = 3'b100
    } ccwc_state_t;
endpackage

// >>> logic/ccwc_sync.sv
/*
 two-flop level synchroniser.
 assumes: input is a slow level from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ccwc_sync
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n,
    // level in and out
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;
    logic next_meta;

    // first flop feeds only the second
    always_comb
    begin
        next_meta = d_i;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> logic/ccwc_branch_check.sv
/*
 decode of a fetched first command word: branch recognition and the
 program-check tests that apply to a branch.
 assumes: word is the storage data of the chaining fetch, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ccwc_branch_check
    import ccwc_pkg::*;
#(
    parameter logic [8:0] ADDR_LIMIT = 9'h007
)
(
    // fetched word and context
    input  wire logic [31:0] word_i,
    input  wire logic        start_io_i,
    input  wire logic        caw_cycle_i,
    input  wire logic        branch_last_i,
    // decode
    output logic             is_branch_o,
    output logic             prog_check_o
);
    // command bits 4 to 7, address bits 8 to 16, bits 29 to 31
    always_comb
    begin
        is_branch_o  = (word_i[27:24] == BRANCH_CODE);
        prog_check_o = is_branch_o && (start_io_i || caw_cycle_i || branch_last_i
                       || (word_i[2:0] != 3'h0) || (word_i[23:15] > ADDR_LIMIT));
    end
endmodule
`default_nettype wire

// >>> sim/ccwc_cu_model.sv
/*
 behavioural control unit at the far side of the chaining sequencer.
 assumes: same clock as the channel; stimulus changes at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ccwc_cu_model
(
    // clock
    input  wire logic       clk_i,
    // reselection handshake
    input  wire logic       sel_start_i,
    output logic            sel_done_o,
    // status and tags
    output logic            status_valid_o,
    output logic [7:0]      status_o,
    output logic            op_in_o
);
    initial
    begin
        sel_done_o     = 1'b0;
        status_valid_o = 1'b0;
        status_o       = 8'h00;
        op_in_o        = 1'b0;
    end

    // one-cycle status pulse; device end may carry the modifier bit
    task automatic send_status(input logic [7:0] st);
        @(negedge clk_i);
        status_o       = st;
        status_valid_o = 1'b1;
        @(negedge clk_i);
        status_valid_o = 1'b0;
        status_o       = ~st; // complement of the status driven: no stale value
    endtask

    // operational-in level, held until changed
    task automatic set_op_in(input logic v);
        @(negedge clk_i);
        op_in_o = v;
    endtask

    // answer reselection after a short, fixed delay
    always @(posedge clk_i)
    begin
        if (sel_start_i)
        begin
            repeat (3) @(negedge clk_i);
            sel_done_o = 1'b1;
            @(negedge clk_i);
            sel_done_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> sim/ccw_chaining_control_tb_top.sv
/*
 self-checking bench for the chaining sequencer with a storage responder.
 assumes: 125 MHz clock, inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ccw_chaining_control_tb_top;
    import ccwc_pkg::*;

    // design side signals
    logic clk_i, resetn_i, stor_req_o, stor_we_o, stor_ack_i;
    logic [ADDR_W-1:0] stor_addr_o, data_addr_o;
    logic [DATA_W-1:0] stor_wdata_o, stor_rdata_i;
    logic [7:0] car_i, status_i, cmd_o, chan_data_o, flags_o;
    logic [15:0] count_o;
    logic data_cycle_i, count_dec_i, burst_i, first_cycle_i, incorrect_len_i;
    logic start_io_i, caw_cycle_i, status_valid_i, sel_start_o, sel_done_i;
    logic op_in_i, cc_latch_o, dc_latch_o, prog_check_o, irq_req_o, busy_o;
    int   mismatches, n_checks;
    logic [DATA_W-1:0] mem [0:15];

    ccwc_chain ccwc_chain_i (.clk_i(clk_i), .resetn_i(resetn_i), .stor_req_o(stor_req_o),
        .stor_we_o(stor_we_o), .stor_addr_o(stor_addr_o), .stor_wdata_o(stor_wdata_o),
        .stor_ack_i(stor_ack_i), .stor_rdata_i(stor_rdata_i), .car_i(car_i),
        .data_cycle_i(data_cycle_i), .count_dec_i(count_dec_i), .burst_i(burst_i),
        .op_in_i(op_in_i), .first_cycle_i(first_cycle_i), .incorrect_len_i(incorrect_len_i),
        .start_io_i(start_io_i), .caw_cycle_i(caw_cycle_i), .status_valid_i(status_valid_i),
        .status_i(status_i), .sel_start_o(sel_start_o), .sel_done_i(sel_done_i),
        .cmd_o(cmd_o), .chan_data_o(chan_data_o), .flags_o(flags_o), .count_o(count_o),
        .data_addr_o(data_addr_o), .cc_latch_o(cc_latch_o), .dc_latch_o(dc_latch_o),
        .prog_check_o(prog_check_o), .irq_req_o(irq_req_o), .busy_o(busy_o));

    ccwc_cu_model ccwc_cu_model_i (.clk_i(clk_i), .sel_start_i(sel_start_o),
        .sel_done_o(sel_done_i), .status_valid_o(status_valid_i), .status_o(status_i),
        .op_in_o(op_in_i));

    // storage: answers a request two cycles later, three when it comes right after an ack; read data with ack
    always @(negedge clk_i)
    begin
        stor_ack_i <= 1'b0;
        if (stor_req_o && !stor_ack_i)
        begin
            @(negedge clk_i);
            stor_ack_i   <= 1'b1;
            stor_rdata_i <= mem[stor_addr_o[5:2]];
            if (stor_we_o)
                mem[stor_addr_o[5:2]] <= stor_wdata_o;
        end
    end

    // reselection pulses, counted where they stand
    int n_sel;
    always @(negedge clk_i)
        if (sel_start_o === 1'b1)
            n_sel++;

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // watch for one irq pulse within a bounded number of cycles
    task automatic irq_seen(output logic seen);
        seen = 1'b0;
        repeat (60)
        begin
            if (irq_req_o === 1'b1)
                seen = 1'b1;
            @(negedge clk_i);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    logic seen;
    logic [7:0] err_st [0:1];
    initial
    begin
        mismatches = 0;
        n_checks = 0;
        resetn_i = 1'b0;
        car_i = 8'h03;
        {data_cycle_i, count_dec_i, burst_i, first_cycle_i} = 4'h0;
        {incorrect_len_i, start_io_i, caw_cycle_i} = 3'h0;
        for (int i = 0; i < 16; i++)
            mem[i] = 32'h0000_0000;
        mem[0] = 32'h0300_0020;
        mem[1] = 32'hc000_0002;
        mem[2] = 32'h0500_0030;
        mem[3] = 32'h4000_0001;
        mem[4] = 32'h0800_0000;
        mem[6] = 32'h0800_0020;
        mem[8] = 32'h0200_0040;
        mem[9] = 32'h4000_0005;
        mem[10] = 32'h0800_0010;
        err_st[0] = 8'h06; // device end with unit check
        err_st[1] = 8'h05; // device end with unit exception
        repeat (12) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        // registers come out of reset cleared
        chk({cmd_o, chan_data_o, flags_o, 8'h00}, 32'h0);
        chk({count_o, 13'h0, cc_latch_o, dc_latch_o, busy_o}, 32'h0);
        $display("test reset done");
        // unit check and unit exception suppress chaining and request irq
        for (int i = 0; i < 2; i++)
        begin
            ccwc_cu_model_i.send_status(err_st[i]);
            irq_seen(seen);
            chk({31'h0, seen}, 32'h1);
            chk({31'h0, cc_latch_o}, 32'h0);
        end
        // incorrect length without the suppress flag also interrupts
        incorrect_len_i = 1'b1;
        ccwc_cu_model_i.send_status(8'h04);
        irq_seen(seen);
        chk({31'h0, seen}, 32'h1);
        incorrect_len_i = 1'b0;
        $display("test suppress done");
        // device end without command chain flag, even in first cycle
        first_cycle_i = 1'b1;
        ccwc_cu_model_i.send_status(8'h44);
        repeat (4) @(negedge clk_i);
        chk({30'h0, cc_latch_o, stor_req_o}, 32'h0);
        first_cycle_i = 1'b0;
        ccwc_cu_model_i.send_status(8'h04);
        repeat (4) @(negedge clk_i);
        chk({30'h0, cc_latch_o, busy_o}, 32'h0);
        $display("test device end done");
        // zero count without the data chain flag starts no chaining
        data_cycle_i = 1'b1;
        count_dec_i = 1'b1;
        @(negedge clk_i);
        data_cycle_i = 1'b0;
        count_dec_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk({count_o, 14'h0, dc_latch_o, stor_req_o}, 32'h0);
        chk({31'h0, prog_check_o}, 32'h0);
        $display("test data cycle done");
        // start: fetch via word 3, then store words 1-2
        start_io_i = 1'b1;
        @(negedge clk_i);
        start_io_i = 1'b0;
        irq_seen(seen);
        chk(mem[14], 32'h0000_0008);
        chk(mem[12], 32'h0000_0020);
        chk(mem[13], 32'hc000_0002);
        // data chaining, operational-in up
        ccwc_cu_model_i.set_op_in(1'b1);
        count_dec_i = 1'b1;
        repeat (2) @(negedge clk_i);
        {count_dec_i, data_cycle_i} = 2'b01;
        @(negedge clk_i);
        data_cycle_i = 1'b0;
        irq_seen(seen);
        chk({14'h0, data_addr_o}, 32'h0000_0030);
        chk({flags_o, 8'h00, count_o}, 32'h4000_0001);
        chk({mem[12][29:0], dc_latch_o, busy_o}, 32'h0000_0080);
        ccwc_cu_model_i.set_op_in(1'b0);
        $display("test data chaining done");
        // nonzero count: no chaining
        ccwc_cu_model_i.send_status(8'h04);
        irq_seen(seen);
        chk({30'h0, cc_latch_o, busy_o}, 32'h0);
        count_dec_i = 1'b1;
        @(negedge clk_i);
        count_dec_i = 1'b0;
        // modifier skip lands on a branch
        ccwc_cu_model_i.send_status(8'h44);
        irq_seen(seen);
        chk({cmd_o, chan_data_o, 16'h0}, 32'h0202_0000);
        chk(mem[14], 32'h0000_0028);
        chk(mem[12], 32'h0200_0040);
        chk(mem[13], 32'h4000_0005);
        chk({n_sel[29:0], cc_latch_o, busy_o}, 32'h0000_0004);
        // immediate operation; branch after branch
        first_cycle_i = 1'b1;
        ccwc_cu_model_i.send_status(8'h04);
        first_cycle_i = 1'b0;
        irq_seen(seen);
        chk({n_sel[28:0], seen, prog_check_o, cc_latch_o}, 32'h0000_000e);
        $display("test command chaining done");
        wrap_up();
    end

    // hang guard
    initial
    begin
        #200000;
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
